// file: inc/id_rom_pkg.sv
// Purpose: constants and types for the module identification page
// Assumes: byte registers at 16-bit page addresses, read-only
// Notes:   field codes and offsets shared by design and bench
package id_rom_pkg;

	// ------------------------------------------------------------
	// page layout
	// ------------------------------------------------------------
	localparam logic [15:0] PAGE_BASE       = 16'h8000;
	localparam logic [15:0] PAGE_LAST       = 16'h807f;
	localparam int          PAGE_BYTES      = 128;
	localparam logic [6:0]  CHECKSUM_INDEX  = 7'h7f;

	// register offsets (full addresses)
	localparam logic [15:0] FORM_FACTOR_CODE_ADDR        = 16'h8000;
	localparam logic [15:0] EXTENDED_IDENTIFIER_ADDR     = 16'h8001;
	localparam logic [15:0] CONNECTOR_TYPE_CODE_ADDR     = 16'h8002;
	localparam logic [15:0] ETHERNET_APP_CODE_ADDR       = 16'h8003;
	localparam logic [15:0] FIBRE_CHANNEL_APP_CODE_ADDR  = 16'h8004;
	localparam logic [15:0] COPPER_LINK_APPLICATION_CODE_ADDR    = 16'h8005;
	localparam logic [15:0] SONET_SDH_APPLICATION_CODE_ADDR      = 16'h8006;
	localparam logic [15:0] OPTICAL_TRANSPORT_APP_ADDR   = 16'h8007;
	localparam logic [15:0] ADDITIONAL_RATES_ADDR        = 16'h8008;
	localparam logic [15:0] LANE_COUNTS_ADDR             = 16'h8009;
	localparam logic [15:0] HARDWARE_SPEC_REVISION_ADDR  = 16'h8068;
	localparam logic [15:0] MANAGEMENT_SPEC_REV_ADDR     = 16'h8069;
	localparam logic [15:0] MODULE_HW_VERSION_ADDR       = 16'h806a;
	localparam logic [15:0] MODULE_FW_VERSION_ADDR       = 16'h806c;
	localparam logic [15:0] DIAG_MONITORING_TYPE_ADDR    = 16'h806e;
	localparam logic [15:0] DIAG_MODULE_CAPABILITY_ADDR  = 16'h806f;
	localparam logic [15:0] DIAG_LANE_CAPABILITY_ADDR    = 16'h8070;
	localparam logic [15:0] ENHANCED_OPTIONS_FIRST_ADDR  = 16'h8071;
	localparam logic [15:0] MAX_POWER_RAMPUP_ADDR        = 16'h8072;
	localparam logic [15:0] MAX_TX_ENABLE_ADDR           = 16'h8073;
	localparam logic [15:0] HOST_LANE_SIGNAL_TYPE_ADDR   = 16'h8074;
	localparam logic [15:0] TOP_SURFACE_STYLE_ADDR       = 16'h8075;
	localparam logic [15:0] MAX_TX_DISABLE_ADDR          = 16'h8076;
	localparam logic [15:0] MAX_POWER_RAMPDOWN_ADDR      = 16'h8077;
	localparam logic [15:0] ENHANCED_OPTIONS_SECOND_ADDR = 16'h8078;
	localparam logic [15:0] TX_MONITOR_CLOCK_ADDR        = 16'h8079;
	localparam logic [15:0] RX_MONITOR_CLOCK_ADDR        = 16'h807a;
	localparam logic [15:0] ENHANCED_OPTIONS_THIRD_ADDR  = 16'h807b;
	localparam logic [15:0] ID_PAGE_CHECKSUM_ADDR        = 16'h807f;

	// ------------------------------------------------------------
	// field layouts and codes
	// ------------------------------------------------------------
	localparam logic [7:0] FORM_FACTOR_UNKNOWN     = 8'h00;
	localparam logic [7:0] FORM_FACTOR_FIRST_RSVD  = 8'h10;
	localparam logic [7:0] CONNECTOR_UNDEFINED     = 8'h00;
	localparam logic [7:0] CONNECTOR_SC            = 8'h01;
	localparam logic [7:0] CONNECTOR_LC            = 8'h07;
	localparam logic [7:0] CONNECTOR_MT_RJ         = 8'h08;
	localparam logic [7:0] CONNECTOR_MPO           = 8'h09;
	localparam logic [7:0] ETHERNET_FIRST_RSVD     = 8'h10;
	localparam logic [7:0] SONET_SDH_FIRST_RSVD    = 8'h04;
	localparam logic [7:0] OPTICAL_TRANSPORT_RSVD  = 8'h0a;
	localparam logic [7:0] APP_UNDEFINED           = 8'h00;
	localparam logic [1:0] LANE_RATIO_RSVD         = 2'h3;
	localparam logic [7:0] RATES_VALID_MASK        = 8'h1f;
	localparam logic [7:0] DIAG_TYPE_VALID_MASK    = 8'h0c;
	localparam logic [7:0] DIAG_LANE_VALID_MASK    = 8'h0f;
	localparam logic [7:0] DIAG_MODULE_VALID_MASK  = 8'hf7;
	localparam logic [7:0] MIN_TRANSITION_TIME     = 8'h01;
	localparam int         REVISION_SCALE          = 10;

	// extended identifier layout
	typedef struct packed {
		logic [1:0] power_class;
		logic [1:0] lane_ratio;
		logic [2:0] wavelength_mux;
		logic       equipment_catalogue_code_present;
	} extended_id_type;

	// lane count layout: zero means sixteen
	typedef struct packed {
		logic [3:0] network_lanes;
		logic [3:0] host_lanes;
	} lane_counts_type;

	// diagnostic monitoring type layout
	typedef struct packed {
		logic [3:0] reserved_high;
		logic       rx_power_is_average;
		logic       tx_power_is_average;
		logic [1:0] reserved_low;
	} diag_monitoring_type;

	// management read/write request
	typedef struct packed {
		logic        read;
		logic        write;
		logic [15:0] addr;
		logic [15:0] wdata;
	} mgmt_request_type;

endpackage

// file: core/module_base_id_rom.sv
// Purpose: read-only identification page of a pluggable transceiver
// Assumes: management controller issues single-cycle read strobes
// Notes:   stored values are strap parameters; checksum computed at build time
`timescale 1ns/10ps

module module_base_id_rom #(
	parameter logic [7:0]  FORM_FACTOR            = 8'h01, // arbitrary value
	parameter logic [1:0]  POWER_CLASS            = 2'h0,
	parameter logic [1:0]  LANE_RATIO             = 2'h2,
	parameter logic [2:0]  WAVELENGTH_MUX         = 3'h0,
	parameter logic        CATALOGUE_CODE_STORED  = 1'b0,
	parameter logic [7:0]  CONNECTOR_TYPE         = 8'h07,
	parameter logic [7:0]  ETHERNET_APP           = 8'h01,
	parameter logic [7:0]  SONET_SDH_APP          = 8'h00,
	parameter logic [7:0]  OPTICAL_TRANSPORT_APP  = 8'h00,
	parameter logic [7:0]  ADDITIONAL_RATES       = 8'h00,
	parameter logic [3:0]  NETWORK_LANES          = 4'h4,
	parameter logic [3:0]  HOST_LANES             = 4'ha,
	parameter int          HW_SPEC_REVISION_X10   = 14,
	parameter int          MGMT_SPEC_REVISION_X10 = 20,
	parameter logic [7:0]  HW_VERSION_MAJOR       = 8'h01,
	parameter logic [7:0]  HW_VERSION_MINOR       = 8'h00,
	parameter logic [7:0]  FW_VERSION_MAJOR       = 8'h01,
	parameter logic [7:0]  FW_VERSION_MINOR       = 8'h00,
	parameter logic        RX_POWER_AVERAGE       = 1'b1,
	parameter logic        TX_POWER_AVERAGE       = 1'b1,
	parameter logic [7:0]  DIAG_MODULE_CAP        = 8'h03,
	parameter logic [7:0]  DIAG_LANE_CAP          = 8'h0f,
	parameter logic [7:0]  ENHANCED_OPTIONS_1     = 8'h00,
	parameter logic [7:0]  RAMPUP_SECONDS         = 8'h01,
	parameter logic [7:0]  TX_ENABLE_SECONDS      = 8'h01,
	parameter logic [7:0]  HOST_LANE_SIGNAL       = 8'h00,
	parameter logic [7:0]  TOP_SURFACE            = 8'h00,
	parameter logic [7:0]  TX_DISABLE_MS          = 8'h01,
	parameter logic [7:0]  RAMPDOWN_SECONDS       = 8'h01,
	parameter logic [7:0]  ENHANCED_OPTIONS_2     = 8'h00,
	parameter logic [7:0]  TX_MONITOR_CLOCK       = 8'h00,
	parameter logic [7:0]  RX_MONITOR_CLOCK       = 8'h00,
	parameter logic [7:0]  ENHANCED_OPTIONS_3     = 8'h00
) (
	input  wire logic                       core_clk,
	input  wire logic                       rst,
	input  wire id_rom_pkg::mgmt_request_type request,
	output logic                            rdata_valid,
	output logic [15:0]                     rdata,
	output logic                            addr_hit
);

	// ------------------------------------------------------------
	// sanitised field values
	// ------------------------------------------------------------

	// clamp a time to the least reportable value of one unit
	function automatic logic [7:0] at_least_one(input logic [7:0] v);
		at_least_one = (v < id_rom_pkg::MIN_TRANSITION_TIME) ?
			id_rom_pkg::MIN_TRANSITION_TIME : v;
	endfunction

	// replace a reserved code by the undefined code
	function automatic logic [7:0] below_or_zero(input logic [7:0] v, input logic [7:0] lim);
		below_or_zero = (v < lim) ? v : id_rom_pkg::APP_UNDEFINED;
	endfunction

	// connector codes other than the defined ones read as undefined
	function automatic logic [7:0] connector_code(input logic [7:0] v);
		case (v)
			id_rom_pkg::CONNECTOR_SC,
			id_rom_pkg::CONNECTOR_LC,
			id_rom_pkg::CONNECTOR_MT_RJ,
			id_rom_pkg::CONNECTOR_MPO: connector_code = v;
			default:                   connector_code = id_rom_pkg::CONNECTOR_UNDEFINED;
		endcase
	endfunction

	localparam logic [7:0] FORM_FACTOR_V =
		below_or_zero(FORM_FACTOR, id_rom_pkg::FORM_FACTOR_FIRST_RSVD);
	localparam logic [1:0] LANE_RATIO_V =
		(LANE_RATIO == id_rom_pkg::LANE_RATIO_RSVD) ? 2'h0 : LANE_RATIO;
	localparam id_rom_pkg::extended_id_type EXT_ID_V = '{
		power_class:                      POWER_CLASS,
		lane_ratio:                       LANE_RATIO_V,
		wavelength_mux:                   WAVELENGTH_MUX,
		equipment_catalogue_code_present: CATALOGUE_CODE_STORED
	};
	localparam logic [7:0] CONNECTOR_V = connector_code(CONNECTOR_TYPE);
	localparam logic [7:0] ETHERNET_V =
		below_or_zero(ETHERNET_APP, id_rom_pkg::ETHERNET_FIRST_RSVD);
	localparam logic [7:0] SONET_V =
		below_or_zero(SONET_SDH_APP, id_rom_pkg::SONET_SDH_FIRST_RSVD);
	localparam logic [7:0] OTN_V =
		below_or_zero(OPTICAL_TRANSPORT_APP, id_rom_pkg::OPTICAL_TRANSPORT_RSVD);
	localparam logic [7:0] RATES_V =
		ADDITIONAL_RATES & id_rom_pkg::RATES_VALID_MASK;
	localparam id_rom_pkg::lane_counts_type LANES_V = '{
		network_lanes: NETWORK_LANES,
		host_lanes:    HOST_LANES
	};
	localparam logic [7:0] HW_REV_V  = 8'(HW_SPEC_REVISION_X10);
	localparam logic [7:0] MGMT_REV_V = 8'(MGMT_SPEC_REVISION_X10);
	localparam id_rom_pkg::diag_monitoring_type DIAG_TYPE_V = '{
		reserved_high:       4'h0,
		rx_power_is_average: RX_POWER_AVERAGE,
		tx_power_is_average: TX_POWER_AVERAGE,
		reserved_low:        2'h0
	};
	localparam logic [7:0] DIAG_MOD_V =
		DIAG_MODULE_CAP & id_rom_pkg::DIAG_MODULE_VALID_MASK;
	localparam logic [7:0] DIAG_LANE_V =
		DIAG_LANE_CAP & id_rom_pkg::DIAG_LANE_VALID_MASK;
	localparam logic [7:0] RAMPUP_V    = at_least_one(RAMPUP_SECONDS);
	localparam logic [7:0] TX_ON_V     = at_least_one(TX_ENABLE_SECONDS);
	localparam logic [7:0] TX_OFF_V    = at_least_one(TX_DISABLE_MS);
	localparam logic [7:0] RAMPDOWN_V  = at_least_one(RAMPDOWN_SECONDS);

	// ------------------------------------------------------------
	// page contents as a constant table
	// ------------------------------------------------------------

	// every unlisted location but the checksum is reserved and reads zero
	function automatic logic [7:0] page_byte(input logic [6:0] idx);
		logic [15:0] a;
		a = id_rom_pkg::PAGE_BASE | {9'h000, idx};
		case (a)
			id_rom_pkg::FORM_FACTOR_CODE_ADDR:        page_byte = FORM_FACTOR_V;
			id_rom_pkg::EXTENDED_IDENTIFIER_ADDR:     page_byte = EXT_ID_V;
			id_rom_pkg::CONNECTOR_TYPE_CODE_ADDR:     page_byte = CONNECTOR_V;
			id_rom_pkg::ETHERNET_APP_CODE_ADDR:       page_byte = ETHERNET_V;
			id_rom_pkg::FIBRE_CHANNEL_APP_CODE_ADDR:  page_byte = id_rom_pkg::APP_UNDEFINED;
			id_rom_pkg::COPPER_LINK_APPLICATION_CODE_ADDR:    page_byte = id_rom_pkg::APP_UNDEFINED;
			id_rom_pkg::SONET_SDH_APPLICATION_CODE_ADDR:      page_byte = SONET_V;
			id_rom_pkg::OPTICAL_TRANSPORT_APP_ADDR:   page_byte = OTN_V;
			id_rom_pkg::ADDITIONAL_RATES_ADDR:        page_byte = RATES_V;
			id_rom_pkg::LANE_COUNTS_ADDR:             page_byte = LANES_V;
			id_rom_pkg::HARDWARE_SPEC_REVISION_ADDR:  page_byte = HW_REV_V;
			id_rom_pkg::MANAGEMENT_SPEC_REV_ADDR:     page_byte = MGMT_REV_V;
			id_rom_pkg::MODULE_HW_VERSION_ADDR:       page_byte = HW_VERSION_MAJOR;
			16'h806b:                                 page_byte = HW_VERSION_MINOR;
			id_rom_pkg::MODULE_FW_VERSION_ADDR:       page_byte = FW_VERSION_MAJOR;
			16'h806d:                                 page_byte = FW_VERSION_MINOR;
			id_rom_pkg::DIAG_MONITORING_TYPE_ADDR:    page_byte = DIAG_TYPE_V;
			id_rom_pkg::DIAG_MODULE_CAPABILITY_ADDR:  page_byte = DIAG_MOD_V;
			id_rom_pkg::DIAG_LANE_CAPABILITY_ADDR:    page_byte = DIAG_LANE_V;
			id_rom_pkg::ENHANCED_OPTIONS_FIRST_ADDR:  page_byte = ENHANCED_OPTIONS_1;
			id_rom_pkg::MAX_POWER_RAMPUP_ADDR:        page_byte = RAMPUP_V;
			id_rom_pkg::MAX_TX_ENABLE_ADDR:           page_byte = TX_ON_V;
			id_rom_pkg::HOST_LANE_SIGNAL_TYPE_ADDR:   page_byte = HOST_LANE_SIGNAL;
			id_rom_pkg::TOP_SURFACE_STYLE_ADDR:       page_byte = TOP_SURFACE;
			id_rom_pkg::MAX_TX_DISABLE_ADDR:          page_byte = TX_OFF_V;
			id_rom_pkg::MAX_POWER_RAMPDOWN_ADDR:      page_byte = RAMPDOWN_V;
			id_rom_pkg::ENHANCED_OPTIONS_SECOND_ADDR: page_byte = ENHANCED_OPTIONS_2;
			id_rom_pkg::TX_MONITOR_CLOCK_ADDR:        page_byte = TX_MONITOR_CLOCK;
			id_rom_pkg::RX_MONITOR_CLOCK_ADDR:        page_byte = RX_MONITOR_CLOCK;
			id_rom_pkg::ENHANCED_OPTIONS_THIRD_ADDR:  page_byte = ENHANCED_OPTIONS_3;
			default:                                  page_byte = 8'h00;
		endcase
	endfunction

	// modulo-256 sum of every location below the checksum
	function automatic logic [7:0] page_sum();
		logic [7:0] s;
		s = 8'h00;
		for (int i = 0; i < id_rom_pkg::PAGE_BYTES - 1; i++) begin
			s = s + page_byte(7'(i));
		end
		page_sum = s;
	endfunction

	localparam logic [7:0] CHECKSUM_V = page_sum();

	// ------------------------------------------------------------
	// read decode
	// ------------------------------------------------------------

	// the page is the lower half of the 8000h..80ffh block
	wire        in_page   = (request.addr[15:7] == id_rom_pkg::PAGE_BASE[15:7]);
	wire  [6:0] index     = request.addr[6:0];
	wire        is_csum   = (index == id_rom_pkg::CHECKSUM_INDEX);
	wire  [7:0] sel_byte  = is_csum ? CHECKSUM_V : page_byte(index);
	wire        take_read = request.read & in_page;

	assign addr_hit = in_page; // writes are accepted and dropped

	// registered read answer, one cycle after the strobe
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rdata_valid <= 1'b0;
			rdata       <= 16'h0000;
		end else begin
			rdata_valid <= take_read;
			if (take_read) begin
				rdata <= {8'h00, sel_byte};
			end
		end
	end

endmodule

// file: tb/id_rom_properties.sv
// Purpose: concurrent checks on the identification page read port
// Assumes: one clock, asynchronous active-high reset
// Notes:   bound to the top module after the module text
`timescale 1ns/10ps
module id_rom_properties (
	input wire logic                         core_clk,
	input wire logic                         rst,
	input wire id_rom_pkg::mgmt_request_type request,
	input wire logic                         rdata_valid,
	input wire logic [15:0]                  rdata,
	input wire logic                         addr_hit
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);
	// read strobe at one address, and at any page address
	function automatic logic rd(input logic [15:0] a);
		return request.read && (request.addr == a);
	endfunction
	wire in_page = (request.addr[15:7] == 9'h100);
	a_valid_on_read: assert property (request.read && in_page |=> rdata_valid)
		else $error("no answer one cycle after a page read");
	a_miss_silent: assert property (!(request.read && in_page) |=> !rdata_valid)
		else $error("answer without a page read");
	a_hit_decode: assert property (addr_hit == in_page)
		else $error("address hit does not match page range");
	a_high_byte_zero: assert property (rdata_valid |-> rdata[15:8] == 8'h00)
		else $error("upper byte of read data not zero");
	a_write_ignored: assert property (request.write && !request.read |=> $stable(rdata))
		else $error("write changed read data");
	a_form_factor: assert property (rd(16'h8000) |=> rdata[7:0] < 8'h10)
		else $error("reserved form factor code read");
	a_lane_ratio: assert property (rd(16'h8001) |=> rdata[5:4] != 2'b11)
		else $error("reserved lane ratio read");
	a_rates_rsvd: assert property (rd(16'h8008) |=> rdata[7:5] == 3'b000)
		else $error("reserved rate bits set");
	a_diag_rsvd: assert property (rd(16'h806e) |=> rdata[7:4] == 4'h0 && rdata[1:0] == 2'b00)
		else $error("reserved diagnostic type bits set");
	a_time_floor: assert property (rd(16'h8072) || rd(16'h8073) || rd(16'h8076) || rd(16'h8077)
		|=> rdata[7:0] >= 8'h01)
		else $error("transition time below one unit");
endmodule

bind module_base_id_rom id_rom_properties u_props (
	.core_clk    (core_clk),
	.rst         (rst),
	.request     (request),
	.rdata_valid (rdata_valid),
	.rdata       (rdata),
	.addr_hit    (addr_hit)
);

// file: tb/host_model.sv
// Purpose: management controller model issuing single-cycle strobes
// Assumes: a page read is answered one cycle after the taking edge
// Notes:   address inverted after each access so stale values never match
`timescale 1ns/10ps
module host_model (
	input  wire logic                   core_clk,
	output id_rom_pkg::mgmt_request_type request,
	input  wire logic                   rdata_valid,
	input  wire logic [15:0]            rdata
);
	// idle bus from time zero
	initial begin
		request = '0;
	end
	// one read strobe; the answer is awaited under a fixed bound
	task automatic read(input logic [15:0] a, output logic [15:0] d, output logic ok);
		ok = 1'b0;
		d = 16'h0000;
		@(posedge core_clk);
		request.read <= 1'b1;
		request.addr <= a;
		@(posedge core_clk);
		request.read <= 1'b0;
		request.addr <= ~a;
		for (int n = 0; n < 3; n++) begin
			@(posedge core_clk);
			if (rdata_valid === 1'b1 && ok === 1'b0) begin
				ok = 1'b1;
				d = rdata;
			end
		end
	endtask
	// one write strobe, data inverted once released
	task automatic write(input logic [15:0] a, input logic [15:0] w);
		@(posedge core_clk);
		request.write <= 1'b1;
		request.addr <= a;
		request.wdata <= w;
		@(posedge core_clk);
		request.write <= 1'b0;
		request.addr <= ~a;
		request.wdata <= ~w;
	endtask
endmodule

// file: tb/testbench.sv
// Purpose: self-checking bench for the identification page
// Assumes: strap values below include reserved codes that must be cleaned
// Notes:   expected bytes and checksum are worked out here
`timescale 1ns/10ps
module testbench;
	localparam logic [79:0]  LOW_BYTES  = 80'h00ef0905000003091f0f;
	localparam logic [159:0] HIGH_BYTES = 160'h0f140203000004f70f550105000001ff00020400;
	logic                         core_clk = 1'b0;
	logic                         rst = 1'b1;
	id_rom_pkg::mgmt_request_type request;
	logic                         rdata_valid;
	logic [15:0]                  rdata;
	logic                         addr_hit;
	int                           n_errors = 0;
	int                           checks = 0;
	// 25 MHz clock
	always #20 core_clk = ~core_clk;
	module_base_id_rom #(
		.FORM_FACTOR(8'h12), .POWER_CLASS(2'h3), .LANE_RATIO(2'h2), .WAVELENGTH_MUX(3'h7),
		.CATALOGUE_CODE_STORED(1'b1), .CONNECTOR_TYPE(8'h09), .ETHERNET_APP(8'h05),
		.SONET_SDH_APP(8'h03), .OPTICAL_TRANSPORT_APP(8'h09), .ADDITIONAL_RATES(8'hff),
		.NETWORK_LANES(4'h0), .HOST_LANES(4'hf), .HW_SPEC_REVISION_X10(15),
		.MGMT_SPEC_REVISION_X10(20), .HW_VERSION_MAJOR(8'h02), .HW_VERSION_MINOR(8'h03),
		.FW_VERSION_MAJOR(8'h00), .FW_VERSION_MINOR(8'h00), .RX_POWER_AVERAGE(1'b0),
		.TX_POWER_AVERAGE(1'b1), .DIAG_MODULE_CAP(8'hff), .DIAG_LANE_CAP(8'hff),
		.ENHANCED_OPTIONS_1(8'h55), .RAMPUP_SECONDS(8'h00), .TX_ENABLE_SECONDS(8'h05),
		.TX_DISABLE_MS(8'h00), .RAMPDOWN_SECONDS(8'hff), .TX_MONITOR_CLOCK(8'h02),
		.RX_MONITOR_CLOCK(8'h04)
	) dut (.core_clk(core_clk), .rst(rst), .request(request), .rdata_valid(rdata_valid),
		.rdata(rdata), .addr_hit(addr_hit));
	host_model host (.core_clk(core_clk), .request(request), .rdata_valid(rdata_valid),
		.rdata(rdata));
	// expected byte at page index, checksum summed over the rest
	function automatic logic [7:0] want(input int i);
		int s;
		s = 0;
		if (i < 10) return LOW_BYTES[79 - 8 * i -: 8];
		if (i >= 104 && i < 124) return HIGH_BYTES[159 - 8 * (i - 104) -: 8];
		if (i != 127) return 8'h00;
		for (int k = 0; k < 127; k++) s = s + want(k);
		return s[7:0];
	endfunction
	task automatic check(input logic [15:0] seen, input logic [15:0] expected, input string what);
		checks++;
		if (seen !== expected) begin
			n_errors++;
			$display("Error at %0t: %s seen %h expected %h", $time, what, seen, expected);
		end
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// every page byte reads its cleaned value, checksum last
	task automatic t_page;
		logic [15:0] d;
		logic        ok;
		for (int i = 0; i < 128; i++) begin
			host.read(id_rom_pkg::PAGE_BASE + 16'(i), d, ok);
			check({15'h0000, ok}, 16'h0001, "no answer");
			check(d, {8'h00, want(i)}, "page byte");
			if (ok !== 1'b1) report_and_stop();
		end
		$display("t_page done at %0t", $time);
	endtask
	// writes to every address leave the whole page unchanged
	task automatic t_writes;
		for (int i = 0; i < 128; i++)
			host.write(id_rom_pkg::PAGE_BASE + 16'(i), 16'hffff ^ 16'(i));
		t_page();
	endtask
	// reads outside the page give no answer and leave data standing
	task automatic t_outside;
		logic [15:0] d;
		logic        ok;
		logic [15:0] held;
		held = rdata;
		for (int i = 0; i < 2; i++) begin
			host.read(i == 0 ? 16'h8080 : 16'h7fff, d, ok);
			check({15'h0000, ok}, 16'h0000, "answer outside page");
			check(rdata, held, "data not held");
		end
		$display("t_outside done at %0t", $time);
	endtask
	// reset in mid-run clears rdata and rdata_valid, first read right after release
	task automatic t_reset;
		logic [15:0] d;
		logic        ok;
		@(posedge core_clk);
		rst <= 1'b1;
		repeat (2) @(posedge core_clk);
		check(rdata, 16'h0000, "reset data");
		check({15'h0000, rdata_valid}, 16'h0000, "reset valid");
		rst <= 1'b0;
		host.read(id_rom_pkg::LANE_COUNTS_ADDR, d, ok);
		check(d, 16'h000f, "first read");
		$display("t_reset done at %0t", $time);
	endtask
	// main sequence
	initial begin
		repeat (20) @(posedge core_clk);
		rst <= 1'b0;
		t_page();
		t_writes();
		t_outside();
		t_reset();
		report_and_stop();
	end
endmodule
